// [include/uc_map.svh]
`ifndef UC_MAP_SVH
`define UC_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// register addresses on the plain register port
`define UC_A_MR0        4'h0
`define UC_A_MR1        4'h1
`define UC_A_MR2        4'h2
`define UC_A_CMD        4'h3
`define UC_A_STAT       4'h4
`define UC_A_TXQ        4'h5
`define UC_A_RXQ        4'h6
`define UC_A_IRQ        4'h7
`define UC_A_BID        4'h8

////////////////////////////////////////////////////////////////////////////////
// command register fields and miscellaneous command codes
`define UC_CMD_TX_EN    0
`define UC_CMD_TX_DIS   1
`define UC_CMD_RX_EN    2
`define UC_CMD_RX_DIS   3
`define UC_CMD_MISC     6:4
`define UC_MISC_TX_RST  3'h1
`define UC_MISC_RX_RST  3'h2
`define UC_MISC_BRK_ON  3'h3
`define UC_MISC_BRK_OFF 3'h4
`define UC_MISC_ERR_RST 3'h5
`define UC_MISC_RTS_ON  3'h6
`define UC_MISC_RTS_OFF 3'h7

////////////////////////////////////////////////////////////////////////////////
// mode register fields
`define UC_MR0_RX1X     0
`define UC_MR0_TX1X     1
`define UC_MR0_TXLVL    5:4
`define UC_MR1_LEN      1:0
`define UC_MR1_PAR_EN   2
`define UC_MR1_PAR_ODD  3
`define UC_MR2_STOP2    0
`define UC_MR2_CTS      4
`define UC_MR2_RTS      5

////////////////////////////////////////////////////////////////////////////////
// transmit bid levels, queue size, bit timing and reset values
`define UC_LVL_FULL     2'h0
`define UC_LVL_240      2'h1
`define UC_LVL_16       2'h2
`define UC_LVL_EMPTY    2'h3
`define UC_FILL_240     9'h0f0
`define UC_FILL_16      9'h010
`define UC_Q_DEPTH      9'h100
`define UC_BASE_LEN     4'h5
`define UC_TICK_LAST    4'hf
`define UC_TICK_MID     4'h7
`define UC_BRK_HI_LAST  4'h1
`define UC_SYNC_RST     4'hf
`define UC_IRQ_COB      2

`endif

// [include/uc_pkg.sv]
package uc_pkg;

  // transmitter and receiver sequencing
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uc_tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_FRAME, RX_BREAK} uc_rx_state_t;

  // queue pointers and fill counts (depth 256)
  typedef logic [7:0] uc_qptr_t;
  typedef logic [8:0] uc_qcnt_t;

endpackage

// [include/uc_q_if.sv]
`timescale 1ns/1ps
// one queue port: the core pushes and pops, the store answers
interface uc_q_if #(parameter int W = 8);
  import uc_pkg::*;
  logic           push;
  logic [W-1:0]   wdata;
  logic           pop;
  logic           flush;
  logic [W-1:0]   rdata;
  uc_qcnt_t       count;
  logic           full;
  logic           empty;
  modport user  (output push, wdata, pop, flush, input rdata, count, full, empty);
  modport store (input push, wdata, pop, flush, output rdata, count, full, empty);
endinterface

// [rtl/uc_pin_sync.sv]
`timescale 1ns/1ps
`include "uc_map.svh"
// two-flop synchronisers for all pins that arrive from outside ref_clk
module uc_pin_sync (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic [3:0]  pins_in,
  output      logic [3:0]  pins_sync
);
  import uc_pkg::*;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
  } uc_sync_state_t;

  uc_sync_state_t s_q, s_d;

  // first stage feeds only the second stage
  always_comb begin
    s_d    = s_q;
    s_d.s1 = pins_in;
    s_d.s2 = s_q.s1;
  end

  // idle-high reset so no false edge is seen at release
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q <= {`UC_SYNC_RST, `UC_SYNC_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign pins_sync = s_q.s2;
endmodule

// [rtl/uc_queue.sv]
`timescale 1ns/1ps
`include "uc_map.svh"
// 256-entry queue; read data is the current head, combinational from the array
module uc_queue #(parameter int W = 8) (
  input  wire logic ref_clk,
  input  wire logic srst,
  uc_q_if.store     q
);
  import uc_pkg::*;

  typedef struct packed {
    uc_qptr_t wp;
    uc_qptr_t rp;
    uc_qcnt_t cnt;
  } uc_queue_state_t;

  uc_queue_state_t s_q, s_d;
  logic [W-1:0]    mem [0:`UC_Q_DEPTH-1];
  logic            do_push;
  logic            do_pop;

  // a push into a full queue is dropped; the core records overrun only for the receive queue, which it never pushes when full
  always_comb begin
    do_push = q.push && (s_q.cnt != `UC_Q_DEPTH);
    do_pop  = q.pop && (s_q.cnt != '0);
    s_d     = s_q;
    if (q.flush) begin
      s_d = '0;
    end else begin
      if (do_push) begin
        s_d.wp = s_q.wp + 8'h01;
      end
      if (do_pop) begin
        s_d.rp = s_q.rp + 8'h01;
      end
      if (do_push && !do_pop) begin
        s_d.cnt = s_q.cnt + 9'h001;
      end else if (do_pop && !do_push) begin
        s_d.cnt = s_q.cnt - 9'h001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // storage carries no reset; pointers define what is valid
  always_ff @(posedge ref_clk) begin
    if (do_push && !q.flush) begin
      mem[s_q.wp] <= q.wdata;
    end
  end

  assign q.rdata = mem[s_q.rp];
  assign q.count = s_q.cnt;
  assign q.full  = (s_q.cnt == `UC_Q_DEPTH);
  assign q.empty = (s_q.cnt == '0);
endmodule

// [rtl/uc_core.sv]
// Operation
// [R1] transmit bid equals empty slots minus one; full queue never bids
// [R2] mode zero bits 5:4 hold off bidding until a fill threshold
// [R3] transmit-space flag is enabled and queue not full
// [R4] first enable sets space and drained flags; any queue write clears drained
// [R5] drained sets only with empty queue after last stop bit
// [R6] frame is start, data LSB first, optional parity, stop bits
// [R7] line stays high and drained is one until a new character
// [R8] queue writes are ignored while the transmitter is disabled
// [R9] disable lets the character in the shifter finish first
// [R10] send-break drives the serial output low continuously
// [R11] transmitter reset stops at once; stays off until re-enabled
// [R12] clear-to-send gating sampled per character start when enabled
// [R13] auto request-to-send marks all queued bytes fully sent
// [R14] receive entries hold eight data and three status bits, unused zero
// [R15] start bit re-sampled mid-bit; high sample rejects it
// [R16] bits sampled at centre LSB first; written after half stop
// [R17] low stop on nonzero char plus half bit low restarts character
// [R18] errors stored with character just before the ready flag rises
// [R19] all-low character loads zero with break status and change cause
// [R20] break ends after two high receiver bit-clock edges
// [R21] 16x receiver phase aligns to the start edge within one tick
// [R22] five receive statuses: three queued, overrun and break change outside
// [R23] transmitter reset drives line high, clears flags, discards queue
// [R24] break holds until stop-break or any reset; here a receiver reset leaves it on
// [R25] each 16x transmit bit lasts sixteen transmit ticks
`timescale 1ns/1ps
`include "uc_map.svh"
module uc_core (
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_we,
  input  wire logic       reg_re,
  output      logic [7:0] reg_rdata,
  input  wire logic       tx_tick16,
  input  wire logic       rx_tick16,
  input  wire logic       tx_bit_clock,
  input  wire logic       rx_bit_clock,
  input  wire logic       rxd,
  input  wire logic       cts_n,
  output      logic       txd,
  output      logic       request_send_out_n,
  output      logic       tx_space_flag,
  output      logic       rx_char_avail_flag,
  output      logic       tx_bid_valid,
  output      logic [7:0] tx_bid_value
);
  import uc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [7:0]   mode_reg_zero;
    logic [7:0]   mode_reg_one;
    logic [7:0]   mode_reg_two;
    logic         tx_en;
    logic         brk;
    logic         drained;
    logic         rts_man;
    uc_tx_state_t ts;
    logic [3:0]   tcnt;
    logic [3:0]   tbits;
    logic [7:0]   tsh;
    logic         tpar;
    logic         tstop2;
    logic         line;
    uc_rx_state_t rs;
    logic [3:0]   rcnt;
    logic [3:0]   rbits;
    logic [7:0]   rsh;
    logic         rpar;
    logic         rzero;
    logic         rx_en;
    logic         ovr;
    logic         cob;
    logic         rxd_p;
    logic         tclk_p;
    logic         rclk_p;
    logic         txd;
    logic         rts_n;
    logic         space;
    logic         avail;
    logic         bid_v;
    logic [7:0]   bid;
    logic [7:0]   rdata;
  } uc_core_state_t;

  localparam uc_core_state_t CORE_RST = '{line: 1'b1, txd: 1'b1, rts_n: 1'b1, rxd_p: 1'b1,
                                          tclk_p: 1'b1, rclk_p: 1'b1, ts: TX_IDLE, rs: RX_IDLE,
                                          default: '0};

  uc_core_state_t s_q, s_d;
  logic [3:0]     pins_s;
  logic           rxd_s;
  logic           tclk_s;
  logic           rclk_s;
  logic           cts_s;
  logic           tx1x_edge;
  logic           rx1x_edge;
  logic           tx_tick;
  logic           tx_bit_end;
  logic           rx_samp;
  logic           fall;
  logic [3:0]     char_last;
  logic [2:0]     misc;
  logic           wr_cmd;
  logic           tx_rst;
  logic           rx_rst;
  logic           brk_char;
  logic           tx_busy;

  uc_q_if #(.W(8))  txq ();
  uc_q_if #(.W(11)) rxq ();

  //////////////////////////////////////////////////////////////////////////////
  // submodules
  uc_pin_sync u_sync (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .pins_in   ({cts_n, tx_bit_clock, rx_bit_clock, rxd}),
    .pins_sync (pins_s)
  );

  uc_queue #(.W(8)) u_txq (
    .ref_clk (ref_clk),
    .srst    (srst),
    .q       (txq.store)
  );

  uc_queue #(.W(11)) u_rxq (
    .ref_clk (ref_clk),
    .srst    (srst),
    .q       (rxq.store)
  );

  assign rxd_s  = pins_s[0];
  assign rclk_s = pins_s[1];
  assign tclk_s = pins_s[2];
  assign cts_s  = pins_s[3];

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d       = s_q;
    txq.push  = 1'b0;
    txq.pop   = 1'b0;
    txq.flush = 1'b0;
    txq.wdata = reg_wdata;
    rxq.push  = 1'b0;
    rxq.pop   = 1'b0;
    rxq.flush = 1'b0;
    rxq.wdata = '0;
    brk_char  = 1'b0;

    // bit-rate strobes; 1x clocks are edges of the synchronised pins
    tx1x_edge  = tclk_s && !s_q.tclk_p;
    rx1x_edge  = rclk_s && !s_q.rclk_p;
    fall       = s_q.rxd_p && !rxd_s;
    s_d.tclk_p = tclk_s;
    s_d.rclk_p = rclk_s;
    s_d.rxd_p  = rxd_s;
    tx_tick    = s_q.mode_reg_zero[`UC_MR0_TX1X] ? tx1x_edge : tx_tick16;
    tx_bit_end = s_q.mode_reg_zero[`UC_MR0_TX1X] ? tx1x_edge
               : (tx_tick16 && (s_q.tcnt == `UC_TICK_LAST)); // R25
    rx_samp    = s_q.mode_reg_zero[`UC_MR0_RX1X] ? rx1x_edge
               : (rx_tick16 && (s_q.rcnt == `UC_TICK_MID));
    char_last  = `UC_BASE_LEN + {2'h0, s_q.mode_reg_one[`UC_MR1_LEN]} - 4'h1;

    // register writes and commands; resets are applied last so they win
    wr_cmd = reg_we && (reg_addr == `UC_A_CMD);
    misc   = reg_wdata[`UC_CMD_MISC];
    tx_rst = wr_cmd && (misc == `UC_MISC_TX_RST);
    rx_rst = wr_cmd && (misc == `UC_MISC_RX_RST);
    if (reg_we) begin
      if (reg_addr == `UC_A_MR0) begin
        s_d.mode_reg_zero = reg_wdata;
      end else if (reg_addr == `UC_A_MR1) begin
        s_d.mode_reg_one = reg_wdata;
      end else if (reg_addr == `UC_A_MR2) begin
        s_d.mode_reg_two = reg_wdata;
      end else if (reg_addr == `UC_A_TXQ && s_q.tx_en) begin // R8
        txq.push    = 1'b1;
        s_d.drained = 1'b0; // R4
      end
    end
    if (wr_cmd) begin
      if (reg_wdata[`UC_CMD_TX_EN] && !s_q.tx_en) begin
        s_d.tx_en   = 1'b1;
        s_d.drained = 1'b1; // R4
      end
      if (reg_wdata[`UC_CMD_TX_DIS]) begin
        s_d.tx_en = 1'b0; // R9
      end
      if (reg_wdata[`UC_CMD_RX_EN]) begin
        s_d.rx_en = 1'b1;
      end
      if (reg_wdata[`UC_CMD_RX_DIS]) begin
        s_d.rx_en = 1'b0;
      end
      case (misc)
        `UC_MISC_BRK_ON:  s_d.brk = 1'b1; // R10
        `UC_MISC_BRK_OFF: s_d.brk = 1'b0; // R24
        `UC_MISC_ERR_RST: begin
          s_d.ovr = 1'b0;
          s_d.cob = 1'b0;
        end
        `UC_MISC_RTS_ON:  s_d.rts_man = 1'b1;
        `UC_MISC_RTS_OFF: s_d.rts_man = 1'b0;
        default: ;
      endcase
    end

    // transmitter: a character is taken only on a bit-rate tick so bits stay whole
    if (s_q.ts != TX_IDLE && tx_tick) begin
      s_d.tcnt = s_q.tcnt + 4'h1;
    end
    case (s_q.ts)
      TX_IDLE: begin
        s_d.line = 1'b1; // R7
        if (tx_tick && s_q.tx_en && !s_q.brk && !txq.empty
            && !(s_q.mode_reg_two[`UC_MR2_CTS] && cts_s)) begin // R12 R9
          txq.pop   = 1'b1;
          s_d.tsh   = txq.rdata;
          s_d.tpar  = s_q.mode_reg_one[`UC_MR1_PAR_ODD];
          s_d.tbits = '0;
          s_d.tcnt  = '0;
          s_d.line  = 1'b0; // R6
          s_d.ts    = TX_START;
        end
      end
      TX_START: begin
        if (tx_bit_end) begin
          s_d.line = s_q.tsh[0]; // R6
          s_d.ts   = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tx_bit_end) begin
          s_d.tpar  = s_q.tpar ^ s_q.tsh[0];
          s_d.tsh   = {1'b0, s_q.tsh[7:1]};
          s_d.tbits = s_q.tbits + 4'h1;
          s_d.line  = s_q.tsh[1];
          if (s_q.tbits == char_last) begin
            s_d.tstop2 = s_q.mode_reg_two[`UC_MR2_STOP2];
            if (s_q.mode_reg_one[`UC_MR1_PAR_EN]) begin
              s_d.line = s_q.tpar ^ s_q.tsh[0];
              s_d.ts   = TX_PAR;
            end else begin
              s_d.line = 1'b1;
              s_d.ts   = TX_STOP;
            end
          end
        end
      end
      TX_PAR: begin
        if (tx_bit_end) begin
          s_d.line = 1'b1;
          s_d.ts   = TX_STOP;
        end
      end
      TX_STOP: begin
        if (tx_bit_end) begin
          if (s_q.tstop2) begin
            s_d.tstop2 = 1'b0;
          end else begin
            s_d.ts = TX_IDLE;
            if (txq.empty && !txq.push) begin
              s_d.drained = 1'b1; // R5 R7
            end
          end
        end
      end
      default: s_d.ts = TX_IDLE;
    endcase

    // receiver; the 16x tick counter restarts on the start edge itself
    if (s_q.rs != RX_IDLE && rx_tick16) begin
      s_d.rcnt = s_q.rcnt + 4'h1;
    end
    case (s_q.rs)
      RX_IDLE: begin
        if (s_q.rx_en && fall) begin
          s_d.rcnt = '0; // R21
          s_d.rs   = RX_START;
        end
      end
      RX_START: begin
        if (rx_samp) begin
          if (rxd_s) begin
            s_d.rs = RX_IDLE; // R15
          end else begin
            s_d.rbits = '0;
            s_d.rsh   = '0; // R14
            s_d.rpar  = s_q.mode_reg_one[`UC_MR1_PAR_ODD];
            s_d.rzero = 1'b1;
            s_d.rs    = RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (rx_samp) begin
          s_d.rsh[s_q.rbits[2:0]] = rxd_s; // R16
          s_d.rpar  = s_q.rpar ^ rxd_s;
          s_d.rzero = s_q.rzero && !rxd_s;
          s_d.rbits = s_q.rbits + 4'h1;
          if (s_q.rbits == char_last) begin
            s_d.rs = s_q.mode_reg_one[`UC_MR1_PAR_EN] ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (rx_samp) begin
          s_d.rpar  = s_q.rpar ^ rxd_s;
          s_d.rzero = s_q.rzero && !rxd_s;
          s_d.rs    = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rx_samp) begin
          // sample at half stop bit: store character with its three flags
          brk_char = s_q.rzero && !rxd_s; // R19
          if (brk_char) begin
            rxq.wdata = {1'b1, 2'h0, 8'h00};
          end else begin
            rxq.wdata = {1'b0, !rxd_s, s_q.mode_reg_one[`UC_MR1_PAR_EN] && s_q.rpar, s_q.rsh}; // R18 R22
          end
          if (rxq.full) begin
            s_d.ovr = 1'b1; // R22
          end else begin
            rxq.push = 1'b1; // R16
          end
          if (brk_char) begin
            s_d.cob   = 1'b1; // R19
            s_d.rbits = '0;
            s_d.rs    = RX_BREAK;
          end else if (!rxd_s) begin
            s_d.rs   = s_q.mode_reg_zero[`UC_MR0_RX1X] ? RX_START : RX_FRAME; // R17
            s_d.rcnt = '0;
          end else begin
            s_d.rs = RX_IDLE; // R17
          end
        end
      end
      RX_FRAME: begin
        // half a bit after the stop sample: still low means a new start bit
        if (rx_tick16 && s_q.rcnt == `UC_TICK_MID) begin
          s_d.rcnt = '0;
          s_d.rs   = rxd_s ? RX_IDLE : RX_START; // R17
        end
      end
      RX_BREAK: begin
        if (rx_samp) begin
          if (!rxd_s) begin
            s_d.rbits = '0;
          end else if (s_q.rbits == `UC_BRK_HI_LAST) begin
            s_d.cob = 1'b1; // R20
            s_d.rs  = RX_IDLE;
          end else begin
            s_d.rbits = s_q.rbits + 4'h1; // R20
          end
        end
      end
      default: s_d.rs = RX_IDLE;
    endcase

    // register reads; data stand only in the cycle after the strobe
    s_d.rdata = '0;
    if (reg_re) begin
      if (reg_addr == `UC_A_MR0) begin
        s_d.rdata = s_q.mode_reg_zero;
      end else if (reg_addr == `UC_A_MR1) begin
        s_d.rdata = s_q.mode_reg_one;
      end else if (reg_addr == `UC_A_MR2) begin
        s_d.rdata = s_q.mode_reg_two;
      end else if (reg_addr == `UC_A_STAT) begin
        s_d.rdata = {rxq.empty ? 3'h0 : rxq.rdata[10:8], s_q.ovr, s_q.drained && s_q.tx_en,
                     s_q.tx_en && !txq.full, rxq.full, !rxq.empty}; // R22 R3
      end else if (reg_addr == `UC_A_RXQ) begin
        s_d.rdata = rxq.rdata[7:0];
        rxq.pop   = 1'b1;
      end else if (reg_addr == `UC_A_IRQ) begin
        s_d.rdata[`UC_IRQ_COB] = s_q.cob;
      end else if (reg_addr == `UC_A_BID) begin
        s_d.rdata = s_q.bid;
      end
    end

    // software resets override everything above
    if (tx_rst) begin
      s_d.tx_en   = 1'b0; // R11
      s_d.brk     = 1'b0; // R24
      s_d.drained = 1'b0; // R23
      s_d.line    = 1'b1; // R23
      s_d.ts      = TX_IDLE; // R11
      txq.push    = 1'b0;
      txq.flush   = 1'b1; // R23
    end
    if (rx_rst) begin
      s_d.rx_en = 1'b0;
      s_d.ovr   = 1'b0;
      s_d.cob   = 1'b0;
      s_d.rs    = RX_IDLE;
      rxq.push  = 1'b0;
      rxq.flush = 1'b1;
    end

    // registered pin and flag outputs
    tx_busy   = (s_d.ts != TX_IDLE) || !txq.empty || txq.push;
    s_d.txd   = s_d.line && !s_d.brk; // R10 R24
    s_d.rts_n = s_q.mode_reg_two[`UC_MR2_RTS] ? !tx_busy : !s_q.rts_man; // R13
    s_d.space = s_d.tx_en && !txq.full; // R3
    s_d.avail = !rxq.empty;
    s_d.bid   = ~txq.count[7:0]; // R1
    case (s_q.mode_reg_zero[`UC_MR0_TXLVL])
      `UC_LVL_240:   s_d.bid_v = txq.count <= `UC_FILL_240; // R2
      `UC_LVL_16:    s_d.bid_v = txq.count <= `UC_FILL_16; // R2
      `UC_LVL_EMPTY: s_d.bid_v = txq.empty; // R2
      default:       s_d.bid_v = !txq.full; // R1
    endcase
    s_d.bid_v = s_d.bid_v && s_q.tx_en;
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q <= CORE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata          = s_q.rdata;
  assign txd                = s_q.txd;
  assign request_send_out_n = s_q.rts_n;
  assign tx_space_flag      = s_q.space;
  assign rx_char_avail_flag = s_q.avail;
  assign tx_bid_valid       = s_q.bid_v;
  assign tx_bid_value       = s_q.bid;
endmodule

// [test/uc_core_props.sv]
`timescale 1ns/1ps
`include "uc_map.svh"
module uc_core_props (
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_we,
  input wire logic       tx_tick16,
  input wire logic       rx_tick16,
  input wire logic       txd,
  input wire logic       request_send_out_n,
  input wire logic       tx_space_flag,
  input wire logic       rx_char_avail_flag,
  input wire logic       tx_bid_valid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic [2:0] misc;
  logic       brk_q;
  // decoded miscellaneous command of this cycle, zero when no command write
  assign misc = (reg_we && reg_addr == `UC_A_CMD) ? reg_wdata[6:4] : 3'h0;
  // break expected on the line; a tx reset ends it as well as break off
  always_ff @(posedge ref_clk) begin
    if (srst || misc == `UC_MISC_BRK_OFF || misc == `UC_MISC_TX_RST) brk_q <= 1'b0;
    else if (misc == `UC_MISC_BRK_ON) brk_q <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_hw_rst;
    disable iff (1'b0) srst |=> txd && request_send_out_n && !tx_space_flag && !tx_bid_valid && !rx_char_avail_flag;
  endproperty
  a_hw_rst: assert property (p_hw_rst) else $error("outputs not idle in reset");
  property p_bid_gate;
    !tx_space_flag && !$past(tx_space_flag) |-> !tx_bid_valid;
  endproperty
  a_bid_gate: assert property (p_bid_gate) else $error("bid without space");
  property p_space_rise;
    $rose(tx_space_flag) |-> $past(reg_we) || $past(reg_we, 2) || $past(tx_tick16) || $past(tx_tick16, 2);
  endproperty
  a_space_rise: assert property (p_space_rise) else $error("space flag rose without cause");
  property p_brk_on;
    misc == `UC_MISC_BRK_ON |-> ##[1:3] !txd;
  endproperty
  a_brk_on: assert property (p_brk_on) else $error("break not started");
  property p_brk_hold;
    brk_q && $past(brk_q, 2) |-> !txd;
  endproperty
  a_brk_hold: assert property (p_brk_hold) else $error("break released early");
  property p_bit_tick;
    $changed(txd) |-> $past(tx_tick16) || $past(reg_we) || $past(srst);
  endproperty
  a_bit_tick: assert property (p_bit_tick) else $error("txd moved off a tick");
  property p_rx_ready;
    $rose(rx_char_avail_flag) |-> $past(rx_tick16, 2) || $past(rx_tick16, 3);
  endproperty
  a_rx_ready: assert property (p_rx_ready) else $error("ready not after stop sample");
  property p_tx_soft_rst;
    misc == `UC_MISC_TX_RST |-> ##[1:3] txd [*8];
  endproperty
  a_tx_soft_rst: assert property (p_tx_soft_rst) else $error("tx reset did not idle line");
endmodule
bind uc_core uc_core_props u_props (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_we, .tx_tick16, .rx_tick16,
  .txd, .request_send_out_n, .tx_space_flag, .rx_char_avail_flag, .tx_bid_valid);

// [test/uc_remote.sv]
`timescale 1ns/1ps
// far transmitter: one bit is sixteen receive ticks, line idles at mark
module uc_remote (
  input wire logic ref_clk,
  input wire logic tick,
  output     logic rxd
);
  initial rxd = 1'b1;
  // frame bits go out lsb first, then the line returns to mark
  task automatic send(input logic [9:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rxd <= f[i];
      repeat (16) @(posedge ref_clk iff tick);
    end
    rxd <= 1'b1;
    @(posedge ref_clk);
  endtask
  // low pulse shorter than half a bit, must not count as a start
  task automatic glitch;
    rxd <= 1'b0;
    repeat (4) @(posedge ref_clk iff tick);
    rxd <= 1'b1;
  endtask
endmodule

// [test/uc_core_tb_top.sv]
`timescale 1ns/1ps
`include "uc_map.svh"
module uc_core_tb_top;
  logic       ref_clk, srst, reg_we, reg_re, tick_q, rxd, txd, request_send_out_n;
  logic       tx_space_flag, rx_char_avail_flag, tx_bid_valid;
  logic [1:0] div_q;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, tx_bid_value, d;
  int         fails, check_count, k;
  uc_core i_dut (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .tx_tick16(tick_q),
    .rx_tick16(tick_q), .tx_bit_clock(1'b0), .rx_bit_clock(1'b0), .rxd, .cts_n(1'b0), .txd, .request_send_out_n,
    .tx_space_flag, .rx_char_avail_flag, .tx_bid_valid, .tx_bid_value);
  uc_remote i_rem (.ref_clk, .tick(tick_q), .rxd);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // 16x tick every fourth cycle keeps a bit at 64 cycles
  always @(posedge ref_clk) begin
    div_q <= div_q + 2'h1;
    tick_q <= (div_q == 2'h3);
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_we <= 1'b1;
    @(posedge ref_clk);
    reg_we <= 1'b0;
    #1;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge ref_clk);
    reg_re <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic wait_low;
    for (int n = 0; txd !== 1'b0; n++) begin
      if (n > 300) begin
        fails++;
        summarize();
      end
      @(posedge ref_clk);
    end
  endtask
  task automatic cnt_low(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge ref_clk);
      if (txd !== 1'b1) c++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_bid;
    wr(`UC_A_TXQ, 8'h11);
    wr(`UC_A_CMD, 8'h01);
    repeat (2) @(posedge ref_clk);
    rd(`UC_A_BID, d);
    chk(d, 8'hff);
    chk({7'h0, tx_bid_valid}, 8'h01);
    chk(tx_bid_value, 8'hff);
    chk({7'h0, tx_space_flag}, 8'h01);
    rd(`UC_A_STAT, d);
    chk(d, 8'h0c);
  endtask
  task automatic t_frame;
    logic [9:0] f;
    f = {1'b1, 8'ha5, 1'b0};
    wr(`UC_A_MR1, 8'h03);
    wr(`UC_A_MR2, 8'h20);
    wr(`UC_A_TXQ, 8'ha5);
    rd(`UC_A_STAT, d);
    chk(d, 8'h04);
    wait_low();
    chk({7'h0, request_send_out_n}, 8'h00);
    repeat (32) @(posedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      chk({7'h0, txd}, {7'h0, f[i]});
      repeat (64) @(posedge ref_clk);
    end
    rd(`UC_A_STAT, d);
    chk(d, 8'h0c);
    chk({6'h0, request_send_out_n, txd}, 8'h03);
  endtask
  task automatic t_break;
    wr(`UC_A_CMD, 8'h30);
    repeat (300) @(posedge ref_clk);
    chk({7'h0, txd}, 8'h00);
    wr(`UC_A_CMD, 8'h40);
    repeat (4) @(posedge ref_clk);
    chk({7'h0, txd}, 8'h01);
  endtask
  // disable in mid-character: that character ends, the queued one waits
  task automatic t_disable;
    wr(`UC_A_TXQ, 8'h5a);
    wr(`UC_A_TXQ, 8'h33);
    wait_low();
    repeat (32) @(posedge ref_clk);
    wr(`UC_A_CMD, 8'h02);
    repeat (63) @(posedge ref_clk);
    chk({7'h0, txd}, 8'h00);
    repeat (600) @(posedge ref_clk);
    cnt_low(700, k);
    chk(k[7:0] | k[9:8], 8'h00);
  endtask
  task automatic t_txrst;
    wr(`UC_A_CMD, 8'h01);
    wait_low();
    repeat (32) @(posedge ref_clk);
    wr(`UC_A_CMD, 8'h10);
    repeat (3) @(posedge ref_clk);
    chk({7'h0, txd}, 8'h01);
    rd(`UC_A_STAT, d);
    chk(d, 8'h00);
    wr(`UC_A_CMD, 8'h01);
    cnt_low(700, k);
    chk(k[7:0] | k[9:8], 8'h00);
  endtask
  task automatic t_rx;
    wr(`UC_A_MR1, 8'h02);
    wr(`UC_A_CMD, 8'h04);
    i_rem.glitch();
    repeat (700) @(posedge ref_clk);
    chk({7'h0, rx_char_avail_flag}, 8'h00);
    i_rem.send({2'b11, 7'h55, 1'b0}, 9);
    repeat (40) @(posedge ref_clk);
    chk({7'h0, rx_char_avail_flag}, 8'h01);
    rd(`UC_A_STAT, d);
    chk(d & 8'hf3, 8'h01);
    rd(`UC_A_RXQ, d);
    chk(d, 8'h55);
    i_rem.send(10'h000, 10);
    repeat (200) @(posedge ref_clk);
    rd(`UC_A_STAT, d);
    chk(d & 8'hb3, 8'h81);
    rd(`UC_A_IRQ, d);
    chk(d & 8'h04, 8'h04);
    rd(`UC_A_RXQ, d);
    chk(d, 8'h00);
    i_rem.send({2'b11, 7'h2a, 1'b0}, 9);
    repeat (40) @(posedge ref_clk);
    rd(`UC_A_RXQ, d);
    chk(d, 8'h2a);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // a hang anywhere is cut short here
  initial begin
    repeat (90000) @(posedge ref_clk);
    fails++;
    summarize();
  end
  initial begin
    srst = 1'b1;
    reg_we = 1'b0;
    reg_re = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    div_q = 2'h0;
    tick_q = 1'b0;
    fails = 0;
    check_count = 0;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    t_bid();
    t_frame();
    t_break();
    t_disable();
    t_txrst();
    t_rx();
    summarize();
  end
endmodule
